// ===== verilog/dprc_top.v
// Secondary bus reset sequencing and slot reset / power-enable outputs.
// Assumes APB master on pclk; slot inputs arrive asynchronously.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "dprc_map.vh"

module dprc_top #(
    parameter NPORT     = 6,
    parameter TICK_CYC  = `DPRC_TICK_CYC,
    parameter MIN_RST   = `DPRC_MIN_RST_CYC
) (
    // APB
    input  wire               pclk,
    input  wire               presetn,
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [11:0]        paddr,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output reg                pready,
    output reg                pslverr,
    // Port state from the switch
    input  wire [NPORT-1:0]   link_up,
    input  wire [NPORT-1:0]   port_hot_reset,
    // SMBus slave register access qualifier
    input  wire               smb_sel_reset_reg,
    // Switch-side controls
    output reg  [NPORT-1:0]   send_hot_reset_ts1,
    output reg  [NPORT-1:0]   flush_port_queue,
    output reg  [NPORT-1:0]   port_logic_reset,
    output reg  [NPORT-1:0]   dn_regs_reset,
    output reg  [NPORT-1:0]   secondary_ur,
    output reg                upstream_busy,
    output reg                smb_zero_read,
    output reg                smb_block_write,
    // Slot pins
    input  wire [NPORT-1:0]   slot_power_good_in_n,
    output reg  [NPORT-1:0]   slot_reset_out_n,
    output reg  [NPORT-1:0]   slot_reset_oe,
    output reg  [NPORT-1:0]   slot_power_enable_out
);

// ****************************************
// Register file
// ****************************************
reg                 up_sbr_q;
reg  [NPORT-1:0]    dn_sbr_q;
reg  [NPORT-1:0]    slot_power_off_ctl_q;
reg  [1:0]          reset_output_mode_sel_q;
reg  [7:0]          power_to_reset_delay_q;
reg  [7:0]          reset_to_power_delay_q;
reg  [NPORT-1:0]    reset_pin_en_q;
reg  [NPORT-1:0]    pg_s1_q;
reg  [NPORT-1:0]    pg_s2_q;
wire [NPORT-1:0]    rst_int_n;
wire [NPORT-1:0]    pwr_on;
wire                wr_en = psel & penable & pwrite & ~pready;
wire                rd_en = psel & penable & ~pwrite & ~pready;
reg  [31:0]         rd_d;
reg                 bad_d;

// ****************************************
// Read mux
// ****************************************
// Unmapped offsets read zero and flag pslverr. The status word is live,
// so software sees the reset state one flop ahead of its pins and power enable as it stands at the pins;
// the power-good bits come from the synchroniser, never from the pin.
always @* begin
    rd_d  = 32'h0;
    bad_d = 1'b0;
    case (paddr)
        `DPRC_UP_BRIDGE_CTL: rd_d = {31'h0, up_sbr_q};
        `DPRC_DN_BRIDGE_CTL: rd_d = {{(32-NPORT){1'b0}}, dn_sbr_q};
        `DPRC_SLOT_CTL:      rd_d = {{(32-NPORT){1'b0}}, slot_power_off_ctl_q};
        `DPRC_HOTPLUG_CFG:   rd_d = {8'h0, reset_to_power_delay_q, power_to_reset_delay_q,
                                     6'h0, reset_output_mode_sel_q};
        `DPRC_STATUS:        rd_d = {{(32-3*NPORT){1'b0}}, ~pg_s2_q, slot_power_enable_out,
                                     ~rst_int_n};
        `DPRC_ACCESS_CTL:    rd_d = {{(32-NPORT){1'b0}}, reset_pin_en_q};
        default:             bad_d = 1'b1;
    endcase
end

// ****************************************
// APB slave
// ****************************************
// Answers one cycle into the access phase: pready pulses for one cycle.
// The write lands at the first access edge; the master still holds the
// request one more edge, and the ~pready term keeps it from writing twice.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready                  <= 1'b0;
        pslverr                 <= 1'b0;
        prdata                  <= 32'h0;
        up_sbr_q                <= 1'b0;
        dn_sbr_q                <= {NPORT{1'b0}};
        slot_power_off_ctl_q    <= {NPORT{1'b1}};
        reset_output_mode_sel_q <= `DPRC_MODE_PWR_EN;
        power_to_reset_delay_q  <= 8'h0;
        reset_to_power_delay_q  <= 8'h0;
        reset_pin_en_q          <= {NPORT{1'b0}};
    end else begin
        pready  <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & bad_d;
        if (rd_en)
            prdata <= rd_d;
        if (wr_en) begin
            case (paddr)
                `DPRC_UP_BRIDGE_CTL: up_sbr_q <= pwdata[0];
                `DPRC_DN_BRIDGE_CTL: dn_sbr_q <= pwdata[NPORT-1:0];
                `DPRC_SLOT_CTL:      slot_power_off_ctl_q <= pwdata[NPORT-1:0];
                `DPRC_HOTPLUG_CFG: begin
                    reset_output_mode_sel_q <= pwdata[`DPRC_MODE_LSB +: 2];
                    power_to_reset_delay_q  <= pwdata[`DPRC_P2R_LSB +: 8];
                    reset_to_power_delay_q  <= pwdata[`DPRC_R2P_LSB +: 8];
                end
                `DPRC_ACCESS_CTL:    reset_pin_en_q <= pwdata[NPORT-1:0];
                default: ;
            endcase
        end
    end
end

// ****************************************
// Secondary bus reset sequencing
// ****************************************
// The reset lasts exactly as long as the software bit; the upstream port
// itself is never reset, so its config path keeps answering.
// Queue flush and unsupported-request marking cover both kinds of bus
// reset; the port logic and register resets follow only the upstream one.
wire [NPORT-1:0] sbr_any = dn_sbr_q | {NPORT{up_sbr_q}};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        send_hot_reset_ts1 <= {NPORT{1'b0}};
        flush_port_queue   <= {NPORT{1'b0}};
        port_logic_reset   <= {NPORT{1'b0}};
        dn_regs_reset      <= {NPORT{1'b0}};
        secondary_ur       <= {NPORT{1'b0}};
        upstream_busy      <= 1'b0;
        smb_zero_read      <= 1'b0;
        smb_block_write    <= 1'b0;
    end else begin
        send_hot_reset_ts1 <= sbr_any & link_up;
        flush_port_queue   <= sbr_any;
        port_logic_reset   <= {NPORT{up_sbr_q}};
        dn_regs_reset      <= {NPORT{up_sbr_q}};
        secondary_ur       <= sbr_any;
        upstream_busy      <= 1'b0;
        smb_zero_read      <= up_sbr_q & smb_sel_reset_reg;
        smb_block_write    <= up_sbr_q & smb_sel_reset_reg;
    end
end

// ****************************************
// Slot reset and power enable, per port
// ****************************************
// Per-slot sequence: OFF (power off, reset held), P2R (power on, waiting
// to release reset), ON (powered, reset free), R2P (reset held, waiting
// to drop power). Mode code 3 has no meaning and behaves as power-enable.
localparam S_OFF     = 2'd0;
localparam S_P2R     = 2'd1;
localparam S_ON      = 2'd2;
localparam S_R2P     = 2'd3;
localparam TW = 16;
localparam MW = 24;
localparam [31:0]   TICK_LAST_W = TICK_CYC - 1;
localparam [31:0]   MIN_LOAD_W  = MIN_RST - 1;
localparam [TW-1:0] TICK_LAST   = TICK_LAST_W[TW-1:0];
localparam [MW-1:0] MIN_LOAD    = MIN_LOAD_W[MW-1:0];

// ****************************************
// Delay tick
// ****************************************
// One prescaler serves every slot, so a delay may start part-way into a
// tick and lasts between n-1 and n whole ticks. Cheaper than a prescaler
// per slot; the error is one tick at most, small against the delays.
reg  [TW-1:0] tick_q;
wire          tick = (tick_q == {TW{1'b0}});

always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        tick_q <= {TW{1'b0}};
    else
        tick_q <= tick ? TICK_LAST : tick_q - 1'b1;
end

// ****************************************
// Power-good synchroniser
// ****************************************
// The pin is asynchronous; only the second flop feeds logic. Both reset
// to the idle level so no false loss of power shows after reset.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pg_s1_q <= {NPORT{1'b1}};
        pg_s2_q <= {NPORT{1'b1}};
    end else begin
        pg_s1_q <= slot_power_good_in_n;
        pg_s2_q <= pg_s1_q;
    end
end

genvar gi;
generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_slot
        reg  [1:0]    st_q;
        reg  [7:0]    dly_q;
        reg  [MW-1:0] min_q;
        reg           pwr_q;
        reg           want_q;
        reg           rst_n_q;
        wire          good  = ~pg_s2_q[gi];
        wire          pgm   = (reset_output_mode_sel_q == `DPRC_MODE_PWR_GOOD);
        wire          hrm   = (reset_output_mode_sel_q == `DPRC_MODE_HOT_RST);
        wire          hr_rq = port_hot_reset[gi] | sbr_any[gi];
        // Power-good loss bypasses want_q so the pin falls one cycle sooner
        wire          pg_drop = pgm & ~good & rst_n_q & (st_q == S_ON);

        assign rst_int_n[gi] = rst_n_q;
        assign pwr_on[gi]    = pwr_q;

        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st_q   <= S_OFF;
                dly_q  <= 8'h0;
                pwr_q  <= 1'b0;
                want_q <= 1'b1;
            end else begin
                case (st_q)
                    S_OFF: begin
                        want_q <= 1'b1;
                        if (!slot_power_off_ctl_q[gi]) begin
                            pwr_q <= 1'b1;
                            dly_q <= power_to_reset_delay_q;
                            st_q  <= S_P2R;
                        end
                    end
                    S_P2R: begin
                        if (slot_power_off_ctl_q[gi]) begin
                            dly_q <= reset_to_power_delay_q;
                            st_q  <= S_R2P;
                        end else if (pgm && !good) begin
                            dly_q <= power_to_reset_delay_q;
                        end else if (dly_q == 8'h0) begin
                            want_q <= 1'b0;
                            st_q   <= S_ON;
                        end else if (tick) begin
                            dly_q <= dly_q - 1'b1;
                        end
                    end
                    S_ON: begin
                        want_q <= hrm & hr_rq;
                        if (slot_power_off_ctl_q[gi]) begin
                            want_q <= 1'b1;
                            dly_q  <= reset_to_power_delay_q;
                            st_q   <= S_R2P;
                        end else if (pgm && !good) begin
                            want_q <= 1'b1;
                            dly_q  <= power_to_reset_delay_q;
                            st_q   <= S_P2R;
                        end
                    end
                    S_R2P: begin
                        want_q <= 1'b1;
                        if (dly_q == 8'h0) begin
                            pwr_q <= 1'b0;
                            st_q  <= S_OFF;
                        end else if (tick) begin
                            dly_q <= dly_q - 1'b1;
                        end
                    end
                    default: st_q <= S_OFF;
                endcase
            end
        end

        // Pulse stretcher: once asserted, the pin cannot release early
        // even if the cause vanishes after one cycle. The count only runs
        // once the cause is gone, so a long cause adds to the minimum.
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                min_q   <= {MW{1'b0}};
                rst_n_q <= 1'b0;
            end else if (want_q || pg_drop) begin
                if (rst_n_q)
                    min_q <= MIN_LOAD;
                rst_n_q <= 1'b0;
            end else if (min_q != {MW{1'b0}}) begin
                min_q <= min_q - 1'b1;
            end else begin
                rst_n_q <= 1'b1;
            end
        end
    end
endgenerate

// ****************************************
// Slot pins
// ****************************************
// Every pin leaves from a flop. The enable stays low out of reset, so the
// reset pins float until software claims them.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        slot_reset_out_n      <= {NPORT{1'b0}};
        slot_reset_oe         <= {NPORT{1'b0}};
        slot_power_enable_out <= {NPORT{1'b0}};
    end else begin
        slot_reset_out_n      <= rst_int_n;
        slot_reset_oe         <= reset_pin_en_q;
        slot_power_enable_out <= pwr_on;
    end
end

endmodule

// ===== verilog/dprc_map.vh
// Constants for the downstream port reset control block.
// Assumes a 32-bit APB register bus; byte addresses, one word each.
`ifndef DPRC_MAP_VH
`define DPRC_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define DPRC_UP_BRIDGE_CTL   12'h000
`define DPRC_DN_BRIDGE_CTL   12'h004
`define DPRC_SLOT_CTL        12'h008
`define DPRC_HOTPLUG_CFG     12'h00c
`define DPRC_STATUS          12'h010
`define DPRC_ACCESS_CTL      12'h014

// ****************************************
// Field positions
// ****************************************
`define DPRC_MODE_LSB        0
`define DPRC_P2R_LSB         8
`define DPRC_R2P_LSB         16
`define DPRC_DLY_W           8
`define DPRC_UNLOCK_BIT      0

// ****************************************
// Reset values and mode codes
// ****************************************
`define DPRC_MODE_PWR_EN     2'h0
`define DPRC_MODE_PWR_GOOD   2'h1
`define DPRC_MODE_HOT_RST    2'h2
`define DPRC_SLOT_CTL_RST    32'h0000003f
`define DPRC_HOTPLUG_RST     32'h00000000

// ****************************************
// Timing
// ****************************************
`define DPRC_MIN_RST_US      200
`define DPRC_CLK_MHZ         250
`define DPRC_MIN_RST_CYC     (`DPRC_MIN_RST_US * `DPRC_CLK_MHZ)
`define DPRC_TICK_CYC        `DPRC_CLK_MHZ

`endif

// ===== tb/dprc_top_chk.sv
// Concurrent checks on the ports of the downstream port reset block.
// Assumes it is bound into dprc_top; slot 0 stands for every slot.
`timescale 1ns/1ps
module dprc_chk #(
    parameter NPORT   = 6,
    parameter MIN_RST = 50000
) (
    // APB
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pready,
    input wire logic             pslverr,
    // Port side
    input wire logic [NPORT-1:0] link_up,
    input wire logic [NPORT-1:0] send_hot_reset_ts1,
    input wire logic [NPORT-1:0] flush_port_queue,
    input wire logic [NPORT-1:0] port_logic_reset,
    input wire logic [NPORT-1:0] dn_regs_reset,
    input wire logic [NPORT-1:0] secondary_ur,
    input wire logic             upstream_busy,
    input wire logic             smb_zero_read,
    input wire logic             smb_block_write,
    // Slot pins
    input wire logic [NPORT-1:0] slot_reset_out_n,
    input wire logic [NPORT-1:0] slot_power_enable_out
);
    // *****
    // Checks
    // *****
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles the slot 0 reset has been low so far
    logic [31:0] low_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 32'h0;
        end else begin
            low_q <= slot_reset_out_n[0] ? 32'h0 : low_q + 32'h1;
        end
    end
    property p_rdy; pready |-> $past(psel && penable); endproperty
    a_rdy: assert property (p_rdy) else $error("pready without access phase");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr outside pready");
    property p_ts1; (send_hot_reset_ts1 & ~$past(link_up)) == '0; endproperty
    a_ts1: assert property (p_ts1) else $error("ts1 on a down link");
    property p_ur; secondary_ur == flush_port_queue; endproperty
    a_ur: assert property (p_ur) else $error("ur differs from flush");
    property p_busy; !upstream_busy; endproperty
    a_busy: assert property (p_busy) else $error("upstream disturbed");
    property p_plr;
        port_logic_reset == dn_regs_reset && (port_logic_reset == '0 || &port_logic_reset);
    endproperty
    a_plr: assert property (p_plr) else $error("port logic reset partial");
    property p_flush; &port_logic_reset |-> &flush_port_queue; endproperty
    a_flush: assert property (p_flush) else $error("queues kept in reset");
    property p_smb; smb_zero_read == smb_block_write && (!smb_zero_read || port_logic_reset[0]);
    endproperty
    a_smb: assert property (p_smb) else $error("smbus blocking wrong");
    property p_off; $fell(slot_power_enable_out[0]) |-> !slot_reset_out_n[0]; endproperty
    a_off: assert property (p_off) else $error("power dropped before reset");
    property p_min; $rose(slot_reset_out_n[0]) |-> low_q >= MIN_RST - 1; endproperty
    a_min: assert property (p_min) else $error("slot reset pulse too short");
    cover property (&port_logic_reset);
    cover property ($rose(slot_reset_out_n[0]));
    cover property (pslverr);
endmodule

bind dprc_top dprc_chk #(.NPORT(NPORT), .MIN_RST(MIN_RST)) u_chk (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .link_up, .send_hot_reset_ts1,
    .flush_port_queue, .port_logic_reset, .dn_regs_reset, .secondary_ur, .upstream_busy,
    .smb_zero_read, .smb_block_write, .slot_reset_out_n, .slot_power_enable_out);

// ===== tb/dprc_slot_model.sv
// Behavioural slot supply: power good follows enable after a ramp.
// Assumes the bench clock; fault forces the good pin inactive.
`timescale 1ns/1ps
module dprc_slot_model #(
    parameter NPORT = 6
) (
    // Slot side
    input  wire logic             pclk,
    input  wire logic [NPORT-1:0] pwr_en,
    input  wire logic [NPORT-1:0] fault,
    output      logic [NPORT-1:0] good_n
);
    // *****
    // Supply ramp
    // *****
    logic [NPORT-1:0] r1_q = '0;
    logic [NPORT-1:0] r2_q = '0;
    // Ramp delay makes reset release really depend on the pin
    always @(posedge pclk) begin
        r1_q <= pwr_en;
        r2_q <= r1_q & pwr_en;
    end
    assign good_n = ~(r2_q & pwr_en) | fault;
endmodule

// ===== tb/test_downstream_port_reset_control.sv
// Self-checking bench for the downstream port reset block.
// Assumes short counts: MIN_RST 20 and TICK_CYC 4 cycles.
`timescale 1ns/1ps
`include "dprc_map.vh"
module test_downstream_port_reset_control;
    localparam MIN_RST = 20;
    localparam TICK    = 4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        smb_sel_reset_reg = 1'b0;
    logic        pready, pslverr, upstream_busy, smb_zero_read, smb_block_write, er;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [5:0]  link_up = 6'h0;
    logic [5:0]  port_hot_reset = 6'h0;
    logic [5:0]  fault = 6'h0;
    logic [5:0]  send_hot_reset_ts1, flush_port_queue, port_logic_reset, dn_regs_reset;
    logic [5:0]  secondary_ur, slot_power_good_in_n, slot_reset_out_n, slot_reset_oe;
    logic [5:0]  slot_power_enable_out;
    int          err_total = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          k;

    always #2 pclk = ~pclk;

    dprc_top #(.TICK_CYC(TICK), .MIN_RST(MIN_RST)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .link_up, .port_hot_reset, .smb_sel_reset_reg, .send_hot_reset_ts1,
        .flush_port_queue, .port_logic_reset, .dn_regs_reset, .secondary_ur, .upstream_busy,
        .smb_zero_read, .smb_block_write, .slot_power_good_in_n, .slot_reset_out_n,
        .slot_reset_oe, .slot_power_enable_out);

    dprc_slot_model #(.NPORT(6)) u_slot (
        .pclk, .pwr_en(slot_power_enable_out), .fault, .good_n(slot_power_good_in_n));

    // *****
    // Helpers
    // *****
    task end_of_test;
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            end_of_test;
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded waits on slot 0; k is the number of cycles taken
    task wait_rst(input logic lvl, input int lim);
        k = 0;
        while (slot_reset_out_n[0] !== lvl && k < lim) begin
            @(posedge pclk);
            #1;
            k++;
        end
    endtask

    task wait_pe(input logic lvl, input int lim);
        k = 0;
        while (slot_power_enable_out[0] !== lvl && k < lim) begin
            @(posedge pclk);
            #1;
            k++;
        end
    endtask

    // *****
    // Scenarios
    // *****
    task t_reset;
        #1;
        chk("oe", slot_reset_oe, 6'h0);
        apb(0, `DPRC_SLOT_CTL, 32'h0);
        chk("slot_ctl", rd, `DPRC_SLOT_CTL_RST);
        apb(1, 12'h018, 32'h1);
        apb(0, 12'h018, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped rd", rd, 32'h0);
    endtask

    task t_up;
        @(posedge pclk);
        link_up <= 6'h05;
        smb_sel_reset_reg <= 1'b1;
        apb(1, `DPRC_UP_BRIDGE_CTL, 32'h1);
        repeat (3) @(posedge pclk);
        #1;
        chk("ts1", send_hot_reset_ts1, 6'h05);
        chk("regs", dn_regs_reset, 6'h3f);
        chk("flush", flush_port_queue, 6'h3f);
        chk("logic", port_logic_reset, 6'h3f);
        chk("ur", secondary_ur, 6'h3f);
        chk("smb", {smb_zero_read, smb_block_write}, 2'b11);
        apb(0, `DPRC_UP_BRIDGE_CTL, 32'h0);
        chk("up cfg", {er, rd[0], upstream_busy}, 3'b010);
        apb(1, `DPRC_UP_BRIDGE_CTL, 32'h0);
        repeat (3) @(posedge pclk);
        #1;
        chk("up rel", {port_logic_reset, flush_port_queue, smb_zero_read}, 13'h0);
    endtask

    task t_dn;
        @(posedge pclk);
        link_up <= 6'h0b;
        apb(1, `DPRC_DN_BRIDGE_CTL, 32'h0c);
        repeat (3) @(posedge pclk);
        #1;
        chk("dn ts1", send_hot_reset_ts1, 6'h08);
        chk("dn flush", flush_port_queue, 6'h0c);
        chk("dn ur", {secondary_ur, smb_zero_read}, {6'h0c, 1'b0});
        apb(0, `DPRC_DN_BRIDGE_CTL, 32'h0);
        chk("dn cfg", {er, rd[5:0], port_logic_reset}, {1'b0, 6'h0c, 6'h0});
        apb(1, `DPRC_DN_BRIDGE_CTL, 32'h0);
        repeat (3) @(posedge pclk);
        #1;
        chk("dn rel", flush_port_queue, 6'h0);
    endtask

    task t_pe;
        apb(1, `DPRC_ACCESS_CTL, 32'h1);
        apb(1, `DPRC_HOTPLUG_CFG, 32'h00030200);
        #1;
        chk("oe on", {slot_reset_oe, slot_reset_out_n[0]}, {6'h01, 1'b0});
        apb(0, `DPRC_HOTPLUG_CFG, 32'h0);
        chk("hp cfg", rd, 32'h00030200);
        apb(1, `DPRC_SLOT_CTL, 32'h3e);
        wait_pe(1, 20);
        chk("pe first", {slot_power_enable_out[0], slot_reset_out_n[0]}, 2'b10);
        wait_rst(1, 100);
        chk("p2r", k >= 2 * TICK - 1 && k <= 2 * TICK + 2, 1'b1);
        repeat (2 * MIN_RST) @(posedge pclk);
        #1;
        chk("pwr on", slot_reset_out_n[0], 1'b1);
        apb(0, `DPRC_STATUS, 32'h0);
        chk("status", rd, 32'h0000107e);
        apb(1, `DPRC_SLOT_CTL, 32'h3f);
        wait_rst(0, 20);
        chk("rst first", slot_power_enable_out[0], 1'b1);
        wait_pe(0, 100);
        chk("r2p", k >= 2 * TICK + 1 && k <= 3 * TICK, 1'b1);
    endtask

    task t_pg;
        apb(1, `DPRC_HOTPLUG_CFG, 32'h00030201);
        apb(1, `DPRC_SLOT_CTL, 32'h3e);
        wait_pe(1, 20);
        wait_rst(1, 100);
        chk("pg rel", k >= 2 * TICK + 3 && slot_reset_out_n[0] === 1'b1, 1'b1);
        @(posedge pclk);
        fault <= 6'h01;
        wait_rst(0, 20);
        chk("pg loss", k <= 6, 1'b1);
        @(posedge pclk);
        fault <= 6'h0;
        wait_rst(1, 100);
        chk("pg min", k >= MIN_RST - 2 && slot_reset_out_n[0] === 1'b1, 1'b1);
        apb(1, `DPRC_SLOT_CTL, 32'h3f);
        wait_pe(0, 100);
    endtask

    task t_hr;
        apb(1, `DPRC_HOTPLUG_CFG, 32'h00030202);
        apb(1, `DPRC_SLOT_CTL, 32'h3e);
        wait_rst(1, 100);
        chk("hr idle", slot_reset_out_n[0], 1'b1);
        @(posedge pclk);
        port_hot_reset <= 6'h01;
        @(posedge pclk);
        port_hot_reset <= 6'h0;
        wait_rst(0, 10);
        chk("hr on", slot_reset_out_n[0], 1'b0);
        wait_rst(1, 100);
        chk("hr min", k >= MIN_RST - 4 && slot_reset_out_n[0] === 1'b1, 1'b1);
        apb(1, `DPRC_DN_BRIDGE_CTL, 32'h1);
        wait_rst(0, 10);
        chk("hr sbr", slot_reset_out_n[0], 1'b0);
        apb(1, `DPRC_DN_BRIDGE_CTL, 32'h0);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_up;
        t_dn;
        t_pe;
        t_pg;
        t_hr;
        end_of_test;
    end
endmodule
